// >>> rtl/dsad_decoder.sv
// data space address decoder with user scratch registers
`timescale 1ns/1ns

module dsad_decoder (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire dsad_pkg::dsad_req_t REQ,
  input wire dsad_pkg::dsad_ptrs_t PTRS,
  input wire logic [3:0] EE_SIZE_KB,
  output dsad_pkg::dsad_rsp_t RSP,
  output logic [7:0] PROG_KB
);
  import dsad_pkg::*;

  typedef struct packed {
    dsad_rsp_t rsp;
    logic [7:0] prog_kb;
    logic [7:0] scr0;
    logic [7:0] scr1;
    logic [7:0] scr2;
  } dsad_state_t;

  dsad_state_t st_r;
  dsad_state_t st_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // data address to target
  function automatic dsad_tgt_t dec_target(input logic [15:0] a);
    if (a < REGF_END) return T_REGF;
    else if (a < STDIO_END) return T_STDIO;
    else if (a < EXTIO_END) return T_EXTIO;
    else if (a >= SRAMB_BASE && a < SRAMB_END) return T_SRAMB;
    else if (a >= SRAMW_BASE && a < SRAMW_END) return T_SRAMW;
    else if (a >= FLASH_BASE && a <= FLASH_LAST) return T_FLASH;
    else return T_NONE;
  endfunction

  // base of each target region; extended io gets 0 and keeps its full data address
  function automatic logic [15:0] tgt_base(input dsad_tgt_t t);
    case (t)
      T_STDIO: return IO_OFFSET;
      T_SRAMB: return SRAMB_BASE;
      T_SRAMW: return SRAMW_BASE;
      T_FLASH: return FLASH_BASE;
      default: return 16'h0000;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // one request decoded per cycle, answer one cycle later
  always_comb
  begin
    logic [15:0] daddr;
    logic [15:0] ptr;
    logic [5:0] ionum;
    logic err;
    dsad_tgt_t tgt;
    logic [7:0] wdat;
    logic [7:0] eekb;
    daddr = 16'h0000;
    ptr = 16'h0000;
    ionum = 6'h00;
    tgt = T_NONE;
    err = 1'b0;
    wdat = REQ.wdata;
    eekb = 8'h00;
    st_nxt = st_r;
    st_nxt.rsp = '0;
    // program part of the shared flash
    case (EE_SIZE_KB)
      4'h1: eekb = 8'h01;
      4'h2: eekb = 8'h02;
      4'h4: eekb = 8'h04;
      4'h8: eekb = 8'h08;
      default: eekb = 8'h00;
    endcase
    st_nxt.prog_kb = FLASH_KB - {eekb[6:0], 1'b0};
    // pointer pick
    case (REQ.ptr_sel)
      P_X: ptr = PTRS.x;
      P_Y: ptr = PTRS.y;
      default: ptr = PTRS.z;
    endcase
    st_nxt.rsp.ptr_idx = (REQ.ptr_sel == P_X) ? PTR_X_IDX :
                         (REQ.ptr_sel == P_Y) ? PTR_Y_IDX : PTR_Z_IDX;
    case (REQ.kind)
      K_IO:
      begin
        err = (REQ.addr[7:0] > IO_LAST) || (REQ.addr[15:8] != 8'h00);
        daddr = {10'h000, REQ.addr[5:0]} + IO_OFFSET;
      end
      K_BIT:
      begin
        err = (REQ.addr[7:0] > BITIO_LAST) || (REQ.addr[15:8] != 8'h00);
        daddr = {10'h000, REQ.addr[5:0]} + IO_OFFSET;
      end
      K_DIRECT: daddr = REQ.addr;
      K_INDIRECT:
      begin
        daddr = (REQ.mode == M_PREDEC) ? ptr - 16'h0001 : ptr;
        st_nxt.rsp.ptr_we = (REQ.mode == M_PREDEC) || (REQ.mode == M_POSTINC);
        st_nxt.rsp.ptr_val = (REQ.mode == M_POSTINC) ? ptr + 16'h0001 : daddr;
      end
      K_DISP:
      begin
        err = (REQ.ptr_sel == P_X) || (REQ.disp > DISP_MAX);
        daddr = ptr + {10'h000, REQ.disp};
      end
      K_PMLOAD:
      begin
        daddr = FLASH_BASE + {1'b0, PTRS.z[14:0]};
        err = (PTRS.z[15:10] >= st_r.prog_kb[5:0]) || REQ.write;
      end
      default: err = 1'b1;
    endcase
    tgt = dec_target(daddr);
    // extended io only via loads and stores (io numbers cannot reach it)
    if (tgt == T_EXTIO && (REQ.kind == K_IO || REQ.kind == K_BIT))
      err = 1'b1;
    if (tgt == T_NONE)
      err = 1'b1;
    st_nxt.rsp.valid = REQ.valid;
    st_nxt.rsp.error = REQ.valid && err;
    st_nxt.rsp.target = (REQ.valid && !err) ? tgt : T_NONE;
    st_nxt.rsp.local_addr = daddr - tgt_base(tgt);
    st_nxt.rsp.ptr_we = st_nxt.rsp.ptr_we && REQ.valid && !err;
    // single bit writes leave every other bit untouched
    if (REQ.kind == K_BIT)
    begin
      st_nxt.rsp.wmask = 8'h01 << REQ.bit_idx;
      wdat = (REQ.bitop == B_SET) ? st_nxt.rsp.wmask : 8'h00;
      st_nxt.rsp.we = (REQ.bitop != B_TEST);
    end
    else
    begin
      st_nxt.rsp.wmask = 8'hFF;
      st_nxt.rsp.we = REQ.write;
    end
    // no write reaches flash from the data space
    if (tgt == T_FLASH)
      st_nxt.rsp.we = 1'b0;
    st_nxt.rsp.we = st_nxt.rsp.we && REQ.valid && !err;
    st_nxt.rsp.wdata = wdat;
    // scratch registers
    ionum = st_nxt.rsp.local_addr[5:0];
    st_nxt.rsp.scr_hit = (st_nxt.rsp.target == T_STDIO) &&
                         (ionum == SCR0_IO || ionum == SCR1_IO || ionum == SCR2_IO);
    st_nxt.rsp.scr_rdata = (ionum == SCR0_IO) ? st_r.scr0 :
                           (ionum == SCR1_IO) ? st_r.scr1 :
                           (ionum == SCR2_IO) ? st_r.scr2 : 8'h00;
    if (st_nxt.rsp.scr_hit && st_nxt.rsp.we)
    begin
      if (ionum == SCR0_IO)
        st_nxt.scr0 = (st_r.scr0 & ~st_nxt.rsp.wmask) | (wdat & st_nxt.rsp.wmask);
      if (ionum == SCR1_IO)
        st_nxt.scr1 = (st_r.scr1 & ~st_nxt.rsp.wmask) | (wdat & st_nxt.rsp.wmask);
      if (ionum == SCR2_IO)
        st_nxt.scr2 = (st_r.scr2 & ~st_nxt.rsp.wmask) | (wdat & st_nxt.rsp.wmask);
    end
    // an idle cycle answers with an all-zero response, no stale fields
    if (!REQ.valid)
      st_nxt.rsp = '0;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // synchronous reset
  always_ff @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      st_r <= '0;
      st_r.prog_kb <= FLASH_KB;
      st_r.scr0 <= SCR_RESET;
      st_r.scr1 <= SCR_RESET;
      st_r.scr2 <= SCR_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // outputs straight from flops
  assign RSP = st_r.rsp;
  assign PROG_KB = st_r.prog_kb;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  regfile_map_a: assert property (
    REQ.valid && REQ.kind == K_DIRECT && REQ.addr < 16'h0020
    |=> RSP.target == T_REGF && RSP.local_addr == $past(REQ.addr))
    else $error("working register address misrouted");
  stdio_map_a: assert property (
    REQ.valid && REQ.kind == K_DIRECT && REQ.addr >= 16'h0020 && REQ.addr < 16'h0060
    |=> RSP.target == T_STDIO && RSP.local_addr == $past(REQ.addr) - 16'h0020)
    else $error("standard io address misrouted");
  extio_map_a: assert property (
    REQ.valid && REQ.kind == K_DIRECT && REQ.addr >= 16'h0060 && REQ.addr <= 16'h00FF
    |=> RSP.target == T_EXTIO && !RSP.error)
    else $error("extended io address misrouted");
  sram_views_a: assert property (
    REQ.valid && REQ.kind == K_DIRECT && REQ.addr >= 16'h2100 && REQ.addr < 16'h2900
    |=> RSP.target == T_SRAMW && RSP.local_addr == $past(REQ.addr) - 16'h2100)
    else $error("word sram view misrouted");
  sram_byte_a: assert property (
    REQ.valid && REQ.kind == K_DIRECT && REQ.addr >= 16'h0100 && REQ.addr < 16'h0900
    |=> RSP.target == T_SRAMB && RSP.local_addr == $past(REQ.addr) - 16'h0100)
    else $error("byte sram misrouted");
  flash_nowrite_a: assert property (
    RSP.target == T_FLASH |-> !RSP.we)
    else $error("write enabled into flash window");
  io_range_a: assert property (
    REQ.valid && REQ.kind == K_IO && REQ.addr[7:0] > 8'h3F |=> RSP.error && !RSP.we)
    else $error("io number above range accepted");
  bit_range_a: assert property (
    REQ.valid && REQ.kind == K_BIT && REQ.addr[7:0] > 8'h1F |=> RSP.error && !RSP.we)
    else $error("bit access above 0x1F accepted");
  bit_mask_a: assert property (
    REQ.valid && REQ.kind == K_BIT && REQ.bitop == B_CLEAR && REQ.addr[15:0] <= 16'h001F
    |=> RSP.we && $onehot(RSP.wmask) && RSP.wdata == 8'h00)
    else $error("bit clear touches other bits");
  postinc_ptr_a: assert property (
    REQ.valid && REQ.kind == K_INDIRECT && REQ.mode == M_POSTINC && REQ.ptr_sel == P_Y
    ##0 dec_target(PTRS.y) != T_NONE
    |=> RSP.ptr_we && RSP.ptr_idx == 5'h1C && RSP.ptr_val == $past(PTRS.y) + 16'h0001)
    else $error("post increment pointer wrong");
  disp_x_a: assert property (
    REQ.valid && REQ.kind == K_DISP && REQ.ptr_sel == P_X |=> RSP.error)
    else $error("displacement on first pointer accepted");
  prog_size_a: assert property (
    (EE_SIZE_KB == 4'h8) [*2] |-> PROG_KB == 8'h10)
    else $error("program flash size wrong for 8KB eeprom");

  cover_flash_read_c: cover property (
    REQ.valid && REQ.kind == K_PMLOAD ##1 RSP.target == T_FLASH);
  cover_predec_c: cover property (
    REQ.valid && REQ.kind == K_INDIRECT && REQ.mode == M_PREDEC ##1 RSP.ptr_we);
  cover_scratch_c: cover property (RSP.scr_hit && RSP.we ##1 RSP.scr_hit);
endmodule

// >>> rtl/dsad_pkg.sv
// shared types and constants of the data space address decoder
package dsad_pkg;
  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [15:0] REGF_END = 16'h0020;    // first address past working regs
  localparam logic [15:0] STDIO_END = 16'h0060;   // first address past standard io
  localparam logic [15:0] EXTIO_END = 16'h0100;   // first address past extended io
  localparam logic [15:0] SRAMB_BASE = 16'h0100;
  localparam logic [15:0] SRAMB_END = 16'h0900;
  localparam logic [15:0] SRAMW_BASE = 16'h2100;
  localparam logic [15:0] SRAMW_END = 16'h2900;
  localparam logic [15:0] FLASH_BASE = 16'h4000;
  localparam logic [15:0] FLASH_LAST = 16'hBFFF;
  localparam logic [15:0] IO_OFFSET = 16'h0020;   // io number to data address
  localparam logic [7:0] IO_LAST = 8'h3F;
  localparam logic [7:0] BITIO_LAST = 8'h1F;
  localparam logic [5:0] DISP_MAX = 6'h3F;        // 63
  localparam logic [4:0] PTR_X_IDX = 5'h1A;       // pointer pairs start at r26
  localparam logic [4:0] PTR_Y_IDX = 5'h1C;
  localparam logic [4:0] PTR_Z_IDX = 5'h1E;
  localparam logic [7:0] FLASH_KB = 8'h20;        // 32KB program flash
  // user scratch registers, io numbers
  localparam logic [5:0] SCR0_IO = 6'h1E;
  localparam logic [5:0] SCR1_IO = 6'h2A;
  localparam logic [5:0] SCR2_IO = 6'h2B;
  localparam logic [7:0] SCR_RESET = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    K_IO = 3'h0, K_BIT = 3'h1, K_DIRECT = 3'h2, K_INDIRECT = 3'h3,
    K_DISP = 3'h4, K_PMLOAD = 3'h5
  } dsad_kind_t;
  typedef enum logic [1:0] {B_SET = 2'h0, B_CLEAR = 2'h1, B_TEST = 2'h2} dsad_bitop_t;
  typedef enum logic [1:0] {M_PLAIN = 2'h0, M_PREDEC = 2'h1, M_POSTINC = 2'h2} dsad_mode_t;
  typedef enum logic [1:0] {P_X = 2'h0, P_Y = 2'h1, P_Z = 2'h2} dsad_ptr_t;
  typedef enum logic [2:0] {
    T_NONE = 3'h0, T_REGF = 3'h1, T_STDIO = 3'h2, T_EXTIO = 3'h3,
    T_SRAMB = 3'h4, T_SRAMW = 3'h5, T_FLASH = 3'h6
  } dsad_tgt_t;

  typedef struct packed {
    logic valid;
    dsad_kind_t kind;
    logic write;
    dsad_bitop_t bitop;
    logic [2:0] bit_idx;
    dsad_ptr_t ptr_sel;
    dsad_mode_t mode;
    logic [5:0] disp;
    logic [15:0] addr;      // direct address or io number in low byte
    logic [7:0] wdata;
  } dsad_req_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } dsad_ptrs_t;

  typedef struct packed {
    logic valid;
    dsad_tgt_t target;
    logic [15:0] local_addr;
    logic we;
    logic [7:0] wdata;
    logic [7:0] wmask;
    logic error;
    logic ptr_we;
    logic [4:0] ptr_idx;
    logic [15:0] ptr_val;
    logic scr_hit;
    logic [7:0] scr_rdata;
  } dsad_rsp_t;
endpackage

// >>> tb/dsad_core.sv
// core side model: pointer pairs r26 to r31 with hardware writeback
`timescale 1ns/1ns
module dsad_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic ld,
  input wire dsad_pkg::dsad_ptrs_t ld_val,
  input wire dsad_pkg::dsad_rsp_t rsp,
  output dsad_pkg::dsad_ptrs_t ptrs
);
  import dsad_pkg::*;
  // loads from the bench, then writeback of auto-modified pointers
  always_ff @(posedge clk)
  begin
    if (rst || ld)
      ptrs <= rst ? '0 : ld_val;
    else if (rsp.valid && rsp.ptr_we && rsp.ptr_idx == PTR_X_IDX)
      ptrs.x <= rsp.ptr_val;
    else if (rsp.valid && rsp.ptr_we && rsp.ptr_idx == PTR_Y_IDX)
      ptrs.y <= rsp.ptr_val;
    else if (rsp.valid && rsp.ptr_we)
      ptrs.z <= rsp.ptr_val;
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench of the data space address decoder
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  import dsad_pkg::*;
  logic REF_CLK = 1'h0;
  logic RESET = 1'h1;
  dsad_req_t REQ = '0;
  dsad_ptrs_t PTRS;
  logic [3:0] EE_SIZE_KB = 4'h0;
  dsad_rsp_t RSP;
  logic [7:0] PROG_KB;
  logic ld = 1'h0;
  dsad_ptrs_t ld_val = '0;
  logic [7:0] scr [4];
  logic [7:0] prog = 8'h20;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  integer seed = 32'hAC5F2391;
  logic [63:0] rv;
  dsad_req_t q;
  logic [15:0] bnd [16] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100,
    16'h08FF, 16'h0900, 16'h20FF, 16'h2100, 16'h28FF, 16'h2900, 16'h3FFF, 16'h4000,
    16'hBFFF, 16'hC000};
  logic [15:0] lo [6] = '{16'h0000, 16'h0020, 16'h0060, 16'h0100, 16'h2100, 16'h4000};
  logic [15:0] hi [6] = '{16'h001F, 16'h005F, 16'h00FF, 16'h08FF, 16'h28FF, 16'hBFFF};
  dsad_tgt_t tg [6] = '{T_REGF, T_STDIO, T_EXTIO, T_SRAMB, T_SRAMW, T_FLASH};

  dsad_decoder dsad_decoder_inst (.REF_CLK(REF_CLK), .RESET(RESET), .REQ(REQ), .PTRS(PTRS),
    .EE_SIZE_KB(EE_SIZE_KB), .RSP(RSP), .PROG_KB(PROG_KB));
  dsad_core dsad_core_inst (.clk(REF_CLK), .rst(RESET), .ld(ld), .ld_val(ld_val), .rsp(RSP),
    .ptrs(PTRS));

  // clock and hang guard
  always #25 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      print_verdict();
    end
  end

  function automatic int sidx(logic [15:0] l);
    return l == 16'h001E ? 0 : l == 16'h002A ? 1 : l == 16'h002B ? 2 : 3;
  endfunction
  function automatic logic [7:0] exp_prog(logic [3:0] s);
    return (s inside {4'h1, 4'h2, 4'h4, 4'h8}) ? 8'h20 - {3'h0, s, 1'h0} : 8'h20;
  endfunction
  function automatic dsad_req_t mk(dsad_kind_t k, logic w, logic [15:0] a,
    dsad_bitop_t b = B_SET, logic [2:0] n = 3'h0, dsad_ptr_t p = P_X,
    dsad_mode_t m = M_PLAIN, logic [5:0] d = 6'h00);
    return '{1'h1, k, w, b, n, p, m, d, a, 8'hA5};
  endfunction
  // fields that carry no meaning in a given answer are cleared
  function automatic dsad_rsp_t norm(dsad_rsp_t r);
    if (r.error) r.local_addr = '0;
    if (!r.we) r.wmask = '0;
    r.wdata &= r.wmask;
    if (!r.ptr_we) r.ptr_idx = '0;
    if (!r.ptr_we) r.ptr_val = '0;
    if (!r.scr_hit) r.scr_rdata = '0;
    return r;
  endfunction
  // expected answer from the address map
  function automatic dsad_rsp_t model(dsad_req_t r);
    dsad_rsp_t e;
    logic [15:0] a;
    logic [15:0] p;
    e = '0;
    p = r.ptr_sel == P_X ? PTRS.x : r.ptr_sel == P_Y ? PTRS.y : PTRS.z;
    a = r.kind inside {K_IO, K_BIT} ? {8'h00, r.addr[7:0]} + 16'h0020 : r.addr;
    e.valid = 1'h1;
    e.we = r.write;
    e.wdata = r.wdata;
    e.wmask = 8'hFF;
    e.ptr_idx = r.ptr_sel == P_X ? 5'h1A : r.ptr_sel == P_Y ? 5'h1C : 5'h1E;
    if (r.kind == K_IO)
      e.error = r.addr[7:0] > 8'h3F;
    if (r.kind == K_BIT)
    begin
      e.error = r.addr[7:0] > 8'h1F;
      e.we = r.bitop != B_TEST;
      e.wmask = 8'h01 << r.bit_idx;
      e.wdata = r.bitop == B_SET ? e.wmask : 8'h00;
    end
    if (r.kind == K_INDIRECT)
    begin
      a = r.mode == M_PREDEC ? p - 16'h0001 : p;
      e.ptr_we = r.mode != M_PLAIN;
      e.ptr_val = r.mode == M_PREDEC ? a : p + 16'h0001;
    end
    if (r.kind == K_DISP)
      a = p + {10'h000, r.disp};
    e.error |= r.kind == K_DISP && r.ptr_sel == P_X;
    for (int i = 0; i < 6; i++)
      if (r.kind != K_PMLOAD && a >= lo[i] && a <= hi[i])
      begin
        e.target = tg[i];
        e.local_addr = a - (i == 2 ? 16'h0000 : lo[i]);
        e.we = e.we && i != 5;
      end
    e.error |= r.kind != K_PMLOAD && e.target == T_NONE;
    if (r.kind == K_PMLOAD)
    begin
      e.target = T_FLASH;
      e.local_addr = PTRS.z;
      e.we = 1'h0;
      e.error = r.write || {2'h0, PTRS.z[15:10]} >= prog;
    end
    if (e.error)
    begin
      e.target = T_NONE;
      e.we = 1'h0;
      e.ptr_we = 1'h0;
    end
    e.scr_hit = e.target == T_STDIO && sidx(e.local_addr) < 3;
    e.scr_rdata = scr[sidx(e.local_addr)];
    return e;
  endfunction

  // one request, answer checked one cycle later
  task automatic go(dsad_req_t r);
    dsad_rsp_t e;
    int i;
    e = model(r);
    REQ = r;
    @(negedge REF_CLK);
    `CHK("rsp", norm(e), norm(RSP))
    i = sidx(e.local_addr);
    if (e.scr_hit && e.we)
      scr[i] = (scr[i] & ~e.wmask) | (e.wdata & e.wmask);
  endtask
  task automatic idle();
    REQ = '0;
    @(negedge REF_CLK);
    `CHK("idle", '0, RSP)
  endtask
  task automatic ldp(dsad_ptrs_t v);
    REQ = '0;
    ld_val = v;
    ld = 1'h1;
    @(negedge REF_CLK);
    ld = 1'h0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    scr = '{default: 8'h00};
    repeat (8) @(negedge REF_CLK);
    `CHK("prog_rst", 8'h20, PROG_KB)
    RESET = 1'h0;
    idle();
    for (int i = 0; i < 3; i++)
      go(mk(K_IO, 1'h0, i == 0 ? 16'h001E : 16'h0029 + i[15:0]));
    foreach (bnd[i])
    begin
      go(mk(K_DIRECT, 1'h0, bnd[i]));
      go(mk(K_DIRECT, 1'h1, bnd[i]));
    end
    $display("test map done");
    go(mk(K_IO, 1'h1, 16'h003F));
    go(mk(K_IO, 1'h0, 16'h0040));
    go(mk(K_IO, 1'h1, 16'h002A));
    go(mk(K_DIRECT, 1'h0, 16'h004A));
    for (int b = 0; b < 3; b++)
      go(mk(K_BIT, 1'h0, 16'h001E, dsad_bitop_t'(b), 3'h2));
    go(mk(K_BIT, 1'h0, 16'h001F, B_CLEAR, 3'h7));
    go(mk(K_BIT, 1'h0, 16'h0020, B_SET, 3'h0));
    go(mk(K_IO, 1'h0, 16'h001E));
    $display("test io done");
    ldp({16'h0100, 16'h0150, 16'h08C1});
    go(mk(K_INDIRECT, 1'h0, 16'h0000, B_SET, 3'h0, P_Y, M_POSTINC));
    go(mk(K_INDIRECT, 1'h1, 16'h0000, B_SET, 3'h0, P_X, M_PREDEC));
    go(mk(K_INDIRECT, 1'h0, 16'h0000, B_SET, 3'h0, P_Z, M_PLAIN));
    for (int p = 0; p < 3; p++)
      go(mk(K_DISP, 1'h0, 16'h0000, B_SET, 3'h0, dsad_ptr_t'(p), M_PLAIN, 6'h3F));
    idle();
    `CHK("ptrs", 48'h00FF_0151_08C1, PTRS)
    $display("test pointers done");
    for (int s = 0; s < 17; s++)
    begin
      EE_SIZE_KB = s == 16 ? 4'h8 : s[3:0];
      idle();
      idle();
      `CHK("prog_kb", exp_prog(EE_SIZE_KB), PROG_KB)
    end
    prog = 8'h10;
    for (int z = 0; z < 3; z++)
    begin
      ldp({32'h0, z == 2 ? 16'h4000 : 16'h3FFF});
      go(mk(K_PMLOAD, z == 1, 16'h0000));
    end
    $display("test flash done");
    rv = {$random(seed), $random(seed)};
    EE_SIZE_KB = rv[51:48];
    ldp(rv[47:0]);
    idle();
    prog = exp_prog(EE_SIZE_KB);
    repeat (300)
    begin
      rv = {$random(seed), $random(seed)};
      q = rv[43:0];
      q.valid = 1'h1;
      q.kind = dsad_kind_t'(rv[63:61] % 3'h6);
      q.bitop = dsad_bitop_t'(rv[47:46] % 2'h3);
      q.ptr_sel = dsad_ptr_t'(rv[49:48] % 2'h3);
      q.mode = dsad_mode_t'(rv[51:50] % 2'h3);
      q.write &= q.kind != K_IO;
      if (q.kind inside {K_IO, K_BIT})
        q.addr[15:8] = 8'h00;
      go(q);
    end
    idle();
    $display("test random done");
    print_verdict();
  end
endmodule
